// ===== thermal_pkg.sv
`default_nettype none
// ************************************************************
// thermal monitor shared constants
// ************************************************************
package thermal_pkg;

  localparam int CODE_W = 10;
  localparam int FLAG_W = 4;

  // system power modes as seen from the control unit
  typedef enum logic [2:0] {
    PM_POWER_UP,
    PM_ACTIVE,
    PM_STOP,
    PM_SLEEP,
    PM_FAIL_SLEEP,
    PM_POWER_DOWN
  } pwr_mode_t;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_IRQ_STS  = 8'h08;
  localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
  localparam logic [7:0] REG_CMP_STS  = 8'h10;
  localparam logic [7:0] REG_PUMP_THR = 8'h14;
  localparam logic [7:0] REG_CORE_THR = 8'h18;
  localparam logic [7:0] REG_CODES    = 8'h1C;

  // field positions
  localparam int CTRL_BRIDGE_DRIVER_OFF = 0;
  localparam int CTRL_TRX_OFF  = 1;
  localparam int THR_LO_LSB    = 0;
  localparam int THR_UP_LSB    = 16;
  localparam int CODE_HI_LSB   = 16;
  localparam int STS_LO        = 0;
  localparam int STS_UP        = 1;

  localparam logic [31:0] CTRL_FIELDS = 32'h0000_0003;
  localparam logic [31:0] THR_FIELDS  = 32'h03FF_03FF;
  localparam logic [31:0] FLAG_FIELDS = 32'h0000_000F;

  // converter channels that carry the two sensors
  localparam int PUMP_CHAN = 4;
  localparam int CORE_CHAN = 5;

  // ideal transfer: code 33 at 0 C, 45 at 100 C
  localparam int CODE_AT_0C   = 33;
  localparam int CODE_AT_100C = 45;
  localparam int DEG_SPAN     = 100;
  localparam int WARN_DEG_C   = 135;
  localparam int SHUT_DEG_C   = 190;

  function automatic logic [CODE_W-1:0] temp_to_code(input int deg);
    temp_to_code = CODE_W'(CODE_AT_0C + ((CODE_AT_100C - CODE_AT_0C) * deg) / DEG_SPAN);
  endfunction

  localparam logic [CODE_W-1:0] WARN_CODE = temp_to_code(WARN_DEG_C);
  localparam logic [CODE_W-1:0] SHUT_CODE = temp_to_code(SHUT_DEG_C);
  localparam logic [31:0] THR_RST = (32'(SHUT_CODE) << THR_UP_LSB) | 32'(WARN_CODE);

endpackage
`default_nettype wire

// ===== cmp_if.sv
`default_nettype none
// ************************************************************
// compare channel carrier
// ************************************************************
interface cmp_if;
  logic                          sample;
  logic [thermal_pkg::CODE_W-1:0] code;
  logic [thermal_pkg::CODE_W-1:0] lo_thr;
  logic [thermal_pkg::CODE_W-1:0] up_thr;
  logic [1:0]                    clr_sts;
  logic [1:0]                    clr_irq;
  logic [1:0]                    sts;
  logic [1:0]                    irq;
  logic [1:0]                    live;
  logic [thermal_pkg::CODE_W-1:0] last;

  modport ctl  (output sample, code, lo_thr, up_thr, clr_sts, clr_irq,
                input  sts, irq, live, last);
  modport chan (input  sample, code, lo_thr, up_thr, clr_sts, clr_irq,
                output sts, irq, live, last);
endinterface
`default_nettype wire

// ===== temp_cmp_chan.sv
`default_nettype none
// ************************************************************
// over-limit compare channel
// ************************************************************
module temp_cmp_chan (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // channel carrier
  cmp_if.chan       c
);

  logic [1:0]                     sts_q;
  logic [1:0]                     irq_q;
  logic [1:0]                     live_q;
  logic [thermal_pkg::CODE_W-1:0] last_q;

  // over-limit mode: each limit only checks for a reading above it
  wire logic above_lo = c.code > c.lo_thr;
  wire logic above_up = c.code > c.up_thr;
  wire logic [1:0] hit = c.sample ? {above_up, above_lo} : 2'h0;

  // a crossing in the clearing cycle wins over the clear
  wire logic [1:0] sts_d = hit | (sts_q & ~c.clr_sts);
  wire logic [1:0] irq_d = hit | (irq_q & ~c.clr_irq);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_q  <= 2'h0;
      irq_q  <= 2'h0;
      live_q <= 2'h0;
      last_q <= '0;
    end else begin
      sts_q <= sts_d;
      irq_q <= irq_d;
      if (c.sample) begin
        live_q <= {above_up, above_lo};
        last_q <= c.code;
      end
    end
  end

  assign c.sts  = sts_q;
  assign c.irq  = irq_q;
  assign c.live = live_q;
  assign c.last = last_q;

  a_up_sets_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    c.sample && c.code > c.up_thr |=> sts_q[thermal_pkg::STS_UP] && irq_q[thermal_pkg::STS_UP])
    else $error("upper crossing did not set both flags");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    sts_q[thermal_pkg::STS_LO] && !c.clr_sts[thermal_pkg::STS_LO] |=> sts_q[thermal_pkg::STS_LO])
    else $error("low status flag dropped without a clear");
  a_no_spurious_set: assert property (@(posedge clk_i) disable iff (rst_i)
    !sts_q[thermal_pkg::STS_LO] && !c.sample |=> !sts_q[thermal_pkg::STS_LO])
    else $error("low status flag set without a sample");

endmodule
`default_nettype wire

// ===== thermal_monitor_control.sv
// Chosen here: the placing of the registers and register access over Wishbone.
`default_nettype none
// ************************************************************
// thermal monitor control
// ************************************************************
// Operation
// - both sensors are switched on during the power-up sequence
// - both sensors are switched off when power-down has finished
// - both sensors stay enabled throughout active mode
// - sensors are off in reset, stop, sleep and fail-sleep
// - pump reading feeds compare channel 4, core reading channel 5
// - both channels compare in over-limit mode against two limits
// - reading above the warning limit sets low status and irq flags
// - reading above the upper limit sets upper status and irq flags
// - pump reading above its shutdown limit raises pump overtemp flag
// - core reading above its warning limit raises system warning flag
// - core above shutdown limit raises overtemp, requesting fail-sleep in active mode only
// - warning may optionally switch off bridge driver and transceiver
// - no private interrupt line; compare flags make the request
// - ideal code is 33 at 0 C and 45 at 100 C
module thermal_monitor_control (
  // clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // wishbone slave
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [7:0]                     adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [31:0]                    dat_i,
  output logic      [31:0]                    dat_o,
  output logic                                ack_o,
  // system power control
  input  wire thermal_pkg::pwr_mode_t         pwr_mode_i,
  input  wire logic                           pd_done_i,
  // monitor converter results
  input  wire logic [thermal_pkg::CODE_W-1:0] pump_code_i,
  input  wire logic                           pump_valid_i,
  input  wire logic [thermal_pkg::CODE_W-1:0] core_code_i,
  input  wire logic                           core_valid_i,
  // sensor enables
  output logic                                pump_temp_sensor_en_o,
  output logic                                core_temp_sensor_en_o,
  // thermal flags and actions
  output logic                                pump_overtemp_flag_o,
  output logic                                system_temp_warning_flag_o,
  output logic                                system_overtemp_flag_o,
  output logic                                fail_sleep_req_o,
  output logic                                bridge_driver_off_o,
  output logic                                bus_transceiver_off_o,
  // compare interrupt
  output logic                                cmp_irq_o
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                           input logic [31:0] val,
                                           input logic [31:0] m,
                                           input logic [31:0] fields);
    wr_merge = ((old & ~m) | (val & m)) & fields;
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] ctrl_q;
  logic [31:0] ctrl_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;
  logic [31:0] pump_thr_q;
  logic [31:0] pump_thr_d;
  logic [31:0] core_thr_q;
  logic [31:0] core_thr_d;
  logic        sens_en_q;
  logic        fail_sleep_q;
  logic        bridge_driver_off_q;
  logic        trx_off_q;
  logic        irq_q;

  cmp_if pump_c ();
  cmp_if core_c ();

  // ************************************************************
  // bus decode
  // ************************************************************
  wire logic        req      = cyc_i & stb_i;
  wire logic [7:0]  adr_w    = {adr_i[7:2], 2'b00};
  wire logic        hit_ctrl = adr_w == thermal_pkg::REG_CTRL;
  wire logic        hit_stat = adr_w == thermal_pkg::REG_STATUS;
  wire logic        hit_ists = adr_w == thermal_pkg::REG_IRQ_STS;
  wire logic        hit_mask = adr_w == thermal_pkg::REG_IRQ_MASK;
  wire logic        hit_csts = adr_w == thermal_pkg::REG_CMP_STS;
  wire logic        hit_pthr = adr_w == thermal_pkg::REG_PUMP_THR;
  wire logic        hit_cthr = adr_w == thermal_pkg::REG_CORE_THR;
  wire logic        hit_code = adr_w == thermal_pkg::REG_CODES;
  // writes land on the edge that the master samples ack on
  wire logic        wr_cyc   = req & we_i & ack_q;
  wire logic [31:0] bm       = byte_mask(sel_i);
  wire logic [31:0] wdat     = dat_i & bm;

  // ************************************************************
  // flag vectors: bit 0 pump low, 1 pump up, 2 core low, 3 core up
  // ************************************************************
  wire logic [thermal_pkg::FLAG_W-1:0] irq_vec = {core_c.irq, pump_c.irq};
  wire logic [thermal_pkg::FLAG_W-1:0] sts_vec = {core_c.sts, pump_c.sts};
  wire logic [thermal_pkg::FLAG_W-1:0] irq_clr =
    (wr_cyc & hit_ists) ? wdat[thermal_pkg::FLAG_W-1:0] : '0;
  wire logic [thermal_pkg::FLAG_W-1:0] sts_clr =
    (wr_cyc & hit_csts) ? wdat[thermal_pkg::FLAG_W-1:0] : '0;

  assign ctrl_d     = wr_merge(ctrl_q, dat_i, bm, thermal_pkg::CTRL_FIELDS);
  assign mask_d     = wr_merge(mask_q, dat_i, bm, thermal_pkg::FLAG_FIELDS);
  assign pump_thr_d = wr_merge(pump_thr_q, dat_i, bm, thermal_pkg::THR_FIELDS);
  assign core_thr_d = wr_merge(core_thr_q, dat_i, bm, thermal_pkg::THR_FIELDS);

  // ************************************************************
  // read data
  // ************************************************************
  wire logic [31:0] st_word = {24'h000000, core_c.live, pump_c.live,
                               system_overtemp_flag_o, system_temp_warning_flag_o,
                               pump_overtemp_flag_o, sens_en_q};
  wire logic [31:0] code_word = (32'(core_c.last) << thermal_pkg::CODE_HI_LSB)
                              | 32'(pump_c.last);
  // unmapped words read as zero and are still acknowledged
  wire logic [31:0] rd_word =
    hit_ctrl ? ctrl_q :
    hit_stat ? st_word :
    hit_ists ? 32'(irq_vec) :
    hit_mask ? mask_q :
    hit_csts ? 32'(sts_vec) :
    hit_pthr ? pump_thr_q :
    hit_cthr ? core_thr_q :
    hit_code ? code_word : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q  <= req & ~ack_q;
      rdat_q <= rd_word;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdat_q;

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q     <= 32'h00000000;
      mask_q     <= 32'h00000000;
      pump_thr_q <= thermal_pkg::THR_RST;
      core_thr_q <= thermal_pkg::THR_RST;
    end else if (wr_cyc) begin
      if (hit_ctrl) ctrl_q <= ctrl_d;
      if (hit_mask) mask_q <= mask_d;
      if (hit_pthr) pump_thr_q <= pump_thr_d;
      if (hit_cthr) core_thr_q <= core_thr_d;
    end
  end

  // ************************************************************
  // sensor gating by power mode
  // ************************************************************
  // power-down keeps the sensors alive until the sequence reports done
  wire logic mode_on =
    (pwr_mode_i == thermal_pkg::PM_POWER_UP)
    | (pwr_mode_i == thermal_pkg::PM_ACTIVE)
    | ((pwr_mode_i == thermal_pkg::PM_POWER_DOWN) & ~pd_done_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sens_en_q <= 1'b0;
    end else begin
      sens_en_q <= mode_on;
    end
  end

  assign pump_temp_sensor_en_o = sens_en_q;
  assign core_temp_sensor_en_o = sens_en_q;

  // ************************************************************
  // compare channels
  // ************************************************************
  // readings taken while the sensors are off would be meaningless
  assign pump_c.sample  = sens_en_q & pump_valid_i;
  assign pump_c.code    = pump_code_i;
  assign pump_c.lo_thr  = pump_thr_q[thermal_pkg::THR_LO_LSB +: thermal_pkg::CODE_W];
  assign pump_c.up_thr  = pump_thr_q[thermal_pkg::THR_UP_LSB +: thermal_pkg::CODE_W];
  assign pump_c.clr_sts = sts_clr[1:0];
  assign pump_c.clr_irq = irq_clr[1:0];

  assign core_c.sample  = sens_en_q & core_valid_i;
  assign core_c.code    = core_code_i;
  assign core_c.lo_thr  = core_thr_q[thermal_pkg::THR_LO_LSB +: thermal_pkg::CODE_W];
  assign core_c.up_thr  = core_thr_q[thermal_pkg::THR_UP_LSB +: thermal_pkg::CODE_W];
  assign core_c.clr_sts = sts_clr[3:2];
  assign core_c.clr_irq = irq_clr[3:2];

  temp_cmp_chan pump_chan (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .c     (pump_c)
  );

  temp_cmp_chan core_chan (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .c     (core_c)
  );

  // ************************************************************
  // thermal flags and protective actions
  // ************************************************************
  assign pump_overtemp_flag_o       = pump_c.sts[thermal_pkg::STS_UP];
  assign system_temp_warning_flag_o = core_c.sts[thermal_pkg::STS_LO];
  assign system_overtemp_flag_o     = core_c.sts[thermal_pkg::STS_UP];

  wire logic in_active = pwr_mode_i == thermal_pkg::PM_ACTIVE;
  wire logic irq_d     = |(irq_vec & mask_q[thermal_pkg::FLAG_W-1:0]);

  // registered so the protective gates switch cleanly one edge after the flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_sleep_q <= 1'b0;
      bridge_driver_off_q   <= 1'b0;
      trx_off_q    <= 1'b0;
      irq_q        <= 1'b0;
    end else begin
      fail_sleep_q <= system_overtemp_flag_o & in_active;
      bridge_driver_off_q   <= system_temp_warning_flag_o & ctrl_q[thermal_pkg::CTRL_BRIDGE_DRIVER_OFF];
      trx_off_q    <= system_temp_warning_flag_o & ctrl_q[thermal_pkg::CTRL_TRX_OFF];
      irq_q        <= irq_d;
    end
  end

  assign fail_sleep_req_o      = fail_sleep_q;
  assign bridge_driver_off_o   = bridge_driver_off_q;
  assign bus_transceiver_off_o = trx_off_q;
  assign cmp_irq_o             = irq_q;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_powerup_enable: assert property (
    pwr_mode_i == thermal_pkg::PM_POWER_UP |=> pump_temp_sensor_en_o && core_temp_sensor_en_o)
    else $error("sensors not enabled during power-up");

  a_pd_done_off: assert property (
    pwr_mode_i == thermal_pkg::PM_POWER_DOWN && pd_done_i |=> !sens_en_q)
    else $error("sensors still on after power-down finished");

  a_active_enabled: assert property (
    in_active [*3] |-> sens_en_q && $stable(sens_en_q))
    else $error("sensors dropped while in active mode");

  a_lowpower_off: assert property (
    pwr_mode_i inside {thermal_pkg::PM_STOP, thermal_pkg::PM_SLEEP,
                       thermal_pkg::PM_FAIL_SLEEP} |=> !sens_en_q)
    else $error("sensors enabled in a low-power mode");

  a_reset_off: assert property (
    $fell(rst_i) |-> !pump_temp_sensor_en_o && !cmp_irq_o)
    else $error("outputs not cleared by reset");

  a_pump_shutdown: assert property (
    pump_c.sample && pump_code_i > pump_c.up_thr |=> pump_overtemp_flag_o)
    else $error("pump overtemperature flag missed");

  a_core_warning: assert property (
    core_c.sample && core_code_i > core_c.lo_thr |=> system_temp_warning_flag_o)
    else $error("system warning flag missed");

  a_fail_sleep: assert property (
    core_c.sample && core_code_i > core_c.up_thr && in_active ##1 in_active
    |=> fail_sleep_req_o)
    else $error("fail-sleep not requested on system overtemperature");

  a_bridge_off: assert property (
    system_temp_warning_flag_o && ctrl_q[thermal_pkg::CTRL_BRIDGE_DRIVER_OFF]
    |=> bridge_driver_off_o)
    else $error("bridge driver not switched off on warning");

  a_irq_level: assert property (
    cmp_irq_o == $past(irq_d))
    else $error("interrupt does not follow the unmasked flags");

  a_ack_single: assert property (
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  a_ack_answers: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acknowledged in the next cycle");

  // flags are sticky, so one-sided checks after a crossing are enough
  a_pump_low: assert property (
    pump_c.sample && pump_code_i > pump_c.lo_thr |=> pump_c.sts[thermal_pkg::STS_LO]
    && pump_c.irq[thermal_pkg::STS_LO])
    else $error("pump warning crossing did not set both flags");

  a_core_overtemp: assert property (
    core_c.sample && core_code_i > core_c.up_thr |=> system_overtemp_flag_o)
    else $error("system overtemperature flag missed");

  a_fail_sleep_gated: assert property (
    !in_active |=> !fail_sleep_req_o)
    else $error("fail-sleep requested outside active mode");

  a_trx_off: assert property (
    system_temp_warning_flag_o && ctrl_q[thermal_pkg::CTRL_TRX_OFF]
    |=> bus_transceiver_off_o)
    else $error("transceiver not switched off on warning");

  a_off_no_set: assert property (
    !sens_en_q && !pump_overtemp_flag_o |=> !pump_overtemp_flag_o)
    else $error("pump flag set while the sensors are off");

  c_warn_then_clear: cover property (
    system_temp_warning_flag_o ##[1:20] !system_temp_warning_flag_o);
  c_fail_sleep: cover property (fail_sleep_req_o);
  c_irq_raised: cover property ($rose(cmp_irq_o));
  c_powerdown_done: cover property (
    pwr_mode_i == thermal_pkg::PM_POWER_DOWN ##1 !sens_en_q);

endmodule
`default_nettype wire

// ===== converter_model.sv
`default_nettype none
// ************************************************************
// monitor converter model, compare channels 4 and 5
// ************************************************************
module converter_model (
  // clock
  input  wire logic                           clk_i,
  // conversion request from the bench
  input  wire logic                           go_i,
  input  wire logic                           core_sel_i,
  input  wire logic [thermal_pkg::CODE_W-1:0] code_i,
  // channel 4 result
  output logic      [thermal_pkg::CODE_W-1:0] pump_code_o,
  output logic                                pump_valid_o,
  // channel 5 result
  output logic      [thermal_pkg::CODE_W-1:0] core_code_o,
  output logic                                core_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    pump_code_o  = 10'h155;
    core_code_o  = 10'h2AA;
    pump_valid_o = 1'b0;
    core_valid_o = 1'b0;
  end

  // idle code lines toggle so a stale value is never mistaken for a result
  always @(posedge clk_i) begin
    pump_valid_o <= go_i & ~core_sel_i;
    core_valid_o <= go_i & core_sel_i;
    pump_code_o  <= (go_i & ~core_sel_i) ? code_i : ~pump_code_o;
    core_code_o  <= (go_i & core_sel_i) ? code_i : ~core_code_o;
  end
endmodule
`default_nettype wire

// ===== testbench.sv
`default_nettype none
// ************************************************************
// thermal monitor bench
// ************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic                   cyc_i = 1'b0;
  logic                   stb_i = 1'b0;
  logic                   we_i = 1'b0;
  logic [7:0]             adr_i = 8'h00;
  logic [3:0]             sel_i = 4'h0;
  logic [31:0]            dat_i = 32'h0;
  logic                   pd_done_i = 1'b0;
  logic                   go = 1'b0;
  logic                   core_sel = 1'b0;
  logic [9:0]             code = 10'h000;
  thermal_pkg::pwr_mode_t pwr_mode_i = thermal_pkg::PM_POWER_UP;
  wire logic [31:0]       dat_o;
  wire logic [9:0]        pump_code;
  wire logic [9:0]        core_code;
  wire logic              ack_o, pump_valid, core_valid, pump_en, core_en;
  wire logic              pump_ot, warn, system_overtemp_flag, fsr, bd_off, trx_off, irq;
  int                     mismatches = 0;
  int                     check_count = 0;
  int                     cycles = 0;
  integer                 seed = 32'h92AF;
  localparam int          C0 = thermal_pkg::CODE_AT_0C;
  localparam int          C100 = thermal_pkg::CODE_AT_100C;

  always #2 clk_i = ~clk_i;

  converter_model converter_model_inst (.clk_i(clk_i), .go_i(go), .core_sel_i(core_sel),
    .code_i(code), .pump_code_o(pump_code), .pump_valid_o(pump_valid),
    .core_code_o(core_code), .core_valid_o(core_valid));

  thermal_monitor_control thermal_monitor_control_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .pwr_mode_i(pwr_mode_i), .pd_done_i(pd_done_i),
    .pump_code_i(pump_code), .pump_valid_i(pump_valid), .core_code_i(core_code),
    .core_valid_i(core_valid), .pump_temp_sensor_en_o(pump_en),
    .core_temp_sensor_en_o(core_en), .pump_overtemp_flag_o(pump_ot),
    .system_temp_warning_flag_o(warn), .system_overtemp_flag_o(system_overtemp_flag),
    .fail_sleep_req_o(fsr), .bridge_driver_off_o(bd_off),
    .bus_transceiver_off_o(trx_off), .cmp_irq_o(irq));

  function automatic logic [9:0] exp_code(input int deg);
    exp_code = 10'(C0 + ((C100 - C0) * deg) / 100);
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s read %h not %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s is %b not %b", $time, what, got, exp);
    end
  endtask

  // one classic cycle; the answer is taken at the edge that shows ack high
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    repeat (2) @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check_word(q, exp, what);
  endtask

  // flags land one edge after the model's valid pulse, derived outputs one more
  task automatic sample(input logic sel, input logic [9:0] c);
    @(posedge clk_i);
    go <= 1'b1;
    core_sel <= sel;
    code <= c;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    logic [9:0]  lo, up, v;
    logic [6:0]  en_tab;
    logic [31:0] acc;
    logic        c;
    lo = exp_code(thermal_pkg::WARN_DEG_C);
    up = exp_code(thermal_pkg::SHUT_DEG_C);
    en_tab = 7'b0100011;
    repeat (5) @(posedge clk_i);
    check_bit(pump_en, 1'b0, "enable in reset");
    rst_i <= 1'b0;
    // no setup of the monitor itself before use
    rdchk(thermal_pkg::REG_PUMP_THR, {6'h0, up, 6'h0, lo}, "pump limits");
    rdchk(thermal_pkg::REG_CORE_THR, {6'h0, up, 6'h0, lo}, "core limits");
    rdchk(thermal_pkg::REG_IRQ_MASK, 32'h0, "mask reset");
    wr(8'h20, 32'hFFFF_FFFF);
    rdchk(8'h20, 32'h0, "unmapped");
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_i);
      pwr_mode_i <= (i == 6) ? thermal_pkg::PM_POWER_DOWN : thermal_pkg::pwr_mode_t'(i);
      pd_done_i <= (i == 6);
      repeat (3) @(posedge clk_i);
      check_bit(pump_en, en_tab[i], "pump enable");
      check_bit(core_en, en_tab[i], "core enable");
    end
    $display("test power modes done");
    sample(1'b0, 10'h3FF);
    rdchk(thermal_pkg::REG_CMP_STS, 32'h0, "sample while off");
    @(posedge clk_i);
    pwr_mode_i <= thermal_pkg::PM_ACTIVE;
    pd_done_i <= 1'b0;
    sample(1'b0, lo);
    rdchk(thermal_pkg::REG_CMP_STS, 32'h0, "at warning limit");
    sample(1'b0, lo + 10'd1);
    sample(1'b0, up);
    rdchk(thermal_pkg::REG_CMP_STS, 32'h1, "pump above warning");
    sample(1'b0, up + 10'd1);
    check_bit(pump_ot, 1'b1, "pump overtemp");
    sample(1'b1, lo + 10'd1);
    check_bit(warn, 1'b1, "core warning");
    check_bit(fsr, 1'b0, "no fail-sleep yet");
    sample(1'b1, up + 10'd1);
    check_bit(system_overtemp_flag, 1'b1, "core overtemp");
    check_bit(fsr, 1'b1, "fail-sleep request");
    rdchk(thermal_pkg::REG_STATUS, 32'hFF, "status word");
    rdchk(thermal_pkg::REG_CODES, {6'h0, up + 10'd1, 6'h0, up + 10'd1}, "last codes");
    rdchk(thermal_pkg::REG_IRQ_STS, 32'hF, "irq status");
    check_bit(irq, 1'b0, "masked irq");
    wr(thermal_pkg::REG_IRQ_MASK, 32'h2);
    check_bit(irq, 1'b1, "unmasked irq");
    sample(1'b0, C0[9:0]);
    sample(1'b1, C0[9:0]);
    check_bit(pump_ot, 1'b1, "pump flag after cooling");
    check_bit(warn, 1'b1, "warning after cooling");
    // software answers the warning by shedding load
    for (int k = 0; k < 4; k++) begin
      wr(thermal_pkg::REG_CTRL, 32'(k));
      check_bit(bd_off, k[0], "bridge off");
      check_bit(trx_off, k[1], "transceiver off");
    end
    wr(thermal_pkg::REG_IRQ_STS, 32'h2);
    check_bit(irq, 1'b0, "irq after clear");
    rdchk(thermal_pkg::REG_IRQ_STS, 32'hD, "irq status after clear");
    wr(thermal_pkg::REG_CMP_STS, 32'hF);
    wr(thermal_pkg::REG_IRQ_STS, 32'hF);
    check_bit(system_overtemp_flag, 1'b0, "overtemp cleared");
    $display("test thresholds done");
    acc = 32'h0;
    for (int n = 0; n < 24; n++) begin
      c = $random(seed);
      v = 10'($random(seed) & 63);
      sample(c, v);
      acc |= c ? {28'h0, v > up, v > lo, 2'b00} : {30'h0, v > up, v > lo};
    end
    rdchk(thermal_pkg::REG_CMP_STS, acc, "random status");
    rdchk(thermal_pkg::REG_IRQ_STS, acc, "random irq status");
    $display("test random readings done");
    final_report();
  end
endmodule
`default_nettype wire
